// >>> hdl/egear_pkg.sv
package egear_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h04;
	localparam logic [ADDR_W-1:0] REG_SYNC_MODE  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_GEAR_NUM   = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_GEAR_DEN   = 8'h10;
	localparam logic [ADDR_W-1:0] REG_GEAR_RESYN = 8'h14;
	localparam logic [ADDR_W-1:0] REG_INGEAR_THR = 8'h18;
	localparam logic [ADDR_W-1:0] REG_INGEAR_TIM = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_PROF_ACC   = 8'h20;
	localparam logic [ADDR_W-1:0] REG_PROF_DEC   = 8'h24;
	localparam logic [ADDR_W-1:0] REG_HOME_ACC   = 8'h28;
	localparam logic [ADDR_W-1:0] REG_HOME_SPD   = 8'h2C;
	localparam logic [ADDR_W-1:0] REG_SYNC_OFS   = 8'h30;
	localparam logic [ADDR_W-1:0] REG_SLAVE_POS  = 8'h34;
	localparam logic [ADDR_W-1:0] REG_SLAVE_SPD  = 8'h38;
	localparam logic [ADDR_W-1:0] REG_MASTER_POS = 8'h3C;
	localparam logic [1:0]        PHASE_WIN      = 2'h1;

	localparam int CW_START_GEAR  = 4;
	localparam int CW_START_CORR  = 5;
	localparam int CW_DIRECT      = 6;
	localparam int CW_HALT        = 8;
	localparam int CW_START_PHASE = 9;
	localparam int CW_PROF_LSB    = 12;
	localparam int SW_PHASE_DONE  = 8;
	localparam int SW_TARGET      = 10;
	localparam int SW_CORR_OK     = 12;
	localparam int SW_SYNC_ERR    = 15;

	localparam logic [3:0] SYNC_OFF   = 4'h0;
	localparam logic [3:0] SYNC_PDO1  = 4'h1;
	localparam logic [3:0] SYNC_PDO2  = 4'h2;
	localparam logic [3:0] SYNC_PDO3  = 4'h3;
	localparam logic [3:0] SYNC_CYCLE = 4'hA;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam int          SCURVE_SHIFT = 4;
	localparam int          POS_GAIN_SHIFT = 3;
	localparam logic [31:0] SCURVE_MIN_STEP = 32'h0000_0001;

	typedef enum logic [2:0] {ST_IDLE, ST_ACCEL, ST_COUPLED, ST_HALT, ST_CORR} motion_t;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axil_req_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic              newData;
		logic signed [31:0] pos;
		logic signed [31:0] spd;
	} master_in_t;

	typedef struct packed {
		logic signed [31:0] spd;
		logic signed [31:0] pos;
	} drive_out_t;

endpackage : egear_pkg

// >>> hdl/electronic_gear_slave_control.sv
// Function
// - Sync mode 0 off, 1-3 PDO, 10 SYNC; start while off flags error.
// - Sync on PDO 2 or 3 does no master position extrapolation.
// - Master position and speed scaled by numerator/denominator, resync on factor change.
// - Phasing adds profile speed to master speed until offset accumulated.
// - Four phasing profiles, each with offset, speed and acceleration.
// - Control bit 4 starts gearing, ramping with profile acceleration.
// - Status bit 10 set when speed within threshold for in-gear time.
// - While coupled, motion follows master; profile ramps unused.
// - Halt decelerates to zero with profile deceleration, stays enabled.
// - Halt clears target reached at deceleration start, sets at zero speed.
// - Halt release resumes; target reached cleared, set when in gear again.
// - Standard sync engages at current position when master speed first reached.
// - Standard sync uses the engaging position as relative start position.
// - Direct sync locks to master at block start, position loop compensates.
// - Direct sync ramps up along an S-curve after start and halt release; decelerations are linear.
// - Correction moves to target plus sync offset with homing ramps.
// - Status bit 12 low during correction, set on success.
// - Status bit 8 low while correction or phasing runs, high when ended.
`timescale 1ns/1ns
module electronic_gear_slave_control
	import egear_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire axil_req_t         axiReq,
	output axil_rsp_t              axiRsp,
	input  wire master_in_t        masterIn,
	input  wire logic [2:0]        pdoStrobe,
	input  wire logic              syncStrobe,
	input  wire logic              corrTargetValid,
	input  wire logic signed [31:0] corrTargetIn,
	output drive_out_t             driveOut,
	output logic                   syncMissingError
);

	typedef struct packed {
		logic [15:0]        ctrl;
		logic [3:0]         syncMode;
		logic signed [15:0] gearNum;
		logic [15:0]        gearDen;
		logic               gearResync;
		logic [31:0]        inGearThr;
		logic [31:0]        inGearTime;
		logic [31:0]        profAcc;
		logic [31:0]        profDec;
		logic [31:0]        homeAcc;
		logic [31:0]        homeSpd;
		logic signed [31:0] syncOfs;
		logic [3:0][31:0]   phOfs;
		logic [3:0][31:0]   phSpd;
		logic [3:0][31:0]   phAcc;
	} cfg_t;

	typedef struct packed {
		logic              awHave;
		logic [ADDR_W-1:0] awAddr;
		logic              wHave;
		logic [DATA_W-1:0] wData;
		logic [3:0]        wStrb;
	} bus_t;

	typedef struct packed {
		motion_t            state;
		logic signed [31:0] mPos;
		logic signed [31:0] mSpd;
		logic               fresh;
		logic signed [31:0] spd;
		logic signed [31:0] pos;
		logic signed [31:0] engOfs;
		logic signed [31:0] startPos;
		logic [31:0]        accCur;
		logic signed [31:0] phSpdCur;
		logic [31:0]        phRem;
		logic               phNeg;
		logic [1:0]         phSel;
		logic [31:0]        inGearCnt;
		logic               phDone;
		logic               tgtReached;
		logic               corrOk;
		logic               syncErr;
		logic [2:0]         ctrlPrev;
		logic signed [31:0] corrTgt;
		logic signed [15:0] lastNum;
		logic [15:0]        lastDen;
	} eng_t;

	cfg_t      cfg_q, cfg_d;
	bus_t      bus_q, bus_d;
	axil_rsp_t rsp_q, rsp_d;
	eng_t      eng_q, eng_d;

	function automatic logic [31:0] absv(input logic signed [31:0] x);
		absv = x[31] ? 32'(-x) : 32'(x);
	endfunction : absv

	function automatic logic signed [31:0] ramp(input logic signed [31:0] cur, input logic signed [31:0] tgt,
			input logic [31:0] rate);
		logic signed [31:0] diff;
		diff = tgt - cur;
		if (absv(diff) <= rate) begin
			ramp = tgt;
		end else if (diff[31]) begin
			ramp = cur - $signed(rate);
		end else begin
			ramp = cur + $signed(rate);
		end
	endfunction : ramp

	// Division is kept for exact ratios; it is a one-clock combinational path, registered on each master sample.
	function automatic logic signed [31:0] gear(input logic signed [31:0] v, input logic signed [15:0] n,
			input logic [15:0] d);
		logic signed [47:0] p;
		p = 48'(v) * 48'(n);
		if (d == '0) begin
			gear = '0;
		end else begin
			gear = 32'(p / $signed({1'b0, d}));
		end
	endfunction : gear

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		mergeBytes = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				mergeBytes[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction : mergeBytes

	logic [31:0] statusWord;
	always_comb begin
		statusWord = '0;
		statusWord[SW_PHASE_DONE] = eng_q.phDone;
		statusWord[SW_TARGET] = eng_q.tgtReached;
		statusWord[SW_CORR_OK] = eng_q.corrOk;
		statusWord[SW_SYNC_ERR] = eng_q.syncErr;
	end

	always_comb begin
		logic        rdOk;
		logic        wrOk;
		logic [31:0] rd;
		logic [31:0] cur;
		logic [1:0]  pi;
		rdOk = 1'b1;
		wrOk = 1'b1;
		rd = '0;
		cur = '0;
		pi = '0;
		cfg_d = cfg_q;
		bus_d = bus_q;
		rsp_d = rsp_q;
		if (axiReq.awvalid && rsp_q.awready) begin
			bus_d.awHave = 1'b1;
			bus_d.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && rsp_q.wready) begin
			bus_d.wHave = 1'b1;
			bus_d.wData = axiReq.wdata;
			bus_d.wStrb = axiReq.wstrb;
		end
		if (rsp_q.bvalid && axiReq.bready) begin
			rsp_d.bvalid = 1'b0;
		end
		if (bus_q.awHave && bus_q.wHave && !rsp_q.bvalid) begin
			pi = bus_q.awAddr[5:4];
			unique case (bus_q.awAddr)
				REG_CTRL:       cur = 32'(cfg_q.ctrl);
				REG_SYNC_MODE:  cur = 32'(cfg_q.syncMode);
				REG_GEAR_NUM:   cur = 32'(cfg_q.gearNum);
				REG_GEAR_DEN:   cur = 32'(cfg_q.gearDen);
				REG_GEAR_RESYN: cur = 32'(cfg_q.gearResync);
				REG_INGEAR_THR: cur = cfg_q.inGearThr;
				REG_INGEAR_TIM: cur = cfg_q.inGearTime;
				REG_PROF_ACC:   cur = cfg_q.profAcc;
				REG_PROF_DEC:   cur = cfg_q.profDec;
				REG_HOME_ACC:   cur = cfg_q.homeAcc;
				REG_HOME_SPD:   cur = cfg_q.homeSpd;
				REG_SYNC_OFS:   cur = cfg_q.syncOfs;
				default:        cur = '0;
			endcase
			cur = mergeBytes(cur, bus_q.wData, bus_q.wStrb);
			if (bus_q.awAddr[7:6] == PHASE_WIN) begin
				unique case (bus_q.awAddr[3:2])
					2'h0: cfg_d.phOfs[pi] = mergeBytes(cfg_q.phOfs[pi], bus_q.wData, bus_q.wStrb);
					2'h1: cfg_d.phSpd[pi] = mergeBytes(cfg_q.phSpd[pi], bus_q.wData, bus_q.wStrb);
					2'h2: cfg_d.phAcc[pi] = mergeBytes(cfg_q.phAcc[pi], bus_q.wData, bus_q.wStrb);
					2'h3: wrOk = 1'b0;
				endcase
			end else begin
				unique case (bus_q.awAddr)
					REG_CTRL:       cfg_d.ctrl = cur[15:0];
					REG_SYNC_MODE:  cfg_d.syncMode = cur[3:0];
					REG_GEAR_NUM:   cfg_d.gearNum = cur[15:0];
					REG_GEAR_DEN:   cfg_d.gearDen = cur[15:0];
					REG_GEAR_RESYN: cfg_d.gearResync = cur[0];
					REG_INGEAR_THR: cfg_d.inGearThr = cur;
					REG_INGEAR_TIM: cfg_d.inGearTime = cur;
					REG_PROF_ACC:   cfg_d.profAcc = cur;
					REG_PROF_DEC:   cfg_d.profDec = cur;
					REG_HOME_ACC:   cfg_d.homeAcc = cur;
					REG_HOME_SPD:   cfg_d.homeSpd = cur;
					REG_SYNC_OFS:   cfg_d.syncOfs = cur;
					default:        wrOk = 1'b0;
				endcase
			end
			bus_d.awHave = 1'b0;
			bus_d.wHave = 1'b0;
			rsp_d.bvalid = 1'b1;
			rsp_d.bresp = wrOk ? RESP_OKAY : RESP_SLVERR;
		end
		if (rsp_q.rvalid && axiReq.rready) begin
			rsp_d.rvalid = 1'b0;
		end
		if (axiReq.arvalid && rsp_q.arready) begin
			pi = axiReq.araddr[5:4];
			if (axiReq.araddr[7:6] == PHASE_WIN) begin
				unique case (axiReq.araddr[3:2])
					2'h0: rd = cfg_q.phOfs[pi];
					2'h1: rd = cfg_q.phSpd[pi];
					2'h2: rd = cfg_q.phAcc[pi];
					2'h3: rdOk = 1'b0;
				endcase
			end else begin
				unique case (axiReq.araddr)
					REG_CTRL:       rd = 32'(cfg_q.ctrl);
					REG_STATUS:     rd = statusWord;
					REG_SYNC_MODE:  rd = 32'(cfg_q.syncMode);
					REG_GEAR_NUM:   rd = 32'(cfg_q.gearNum);
					REG_GEAR_DEN:   rd = 32'(cfg_q.gearDen);
					REG_GEAR_RESYN: rd = 32'(cfg_q.gearResync);
					REG_INGEAR_THR: rd = cfg_q.inGearThr;
					REG_INGEAR_TIM: rd = cfg_q.inGearTime;
					REG_PROF_ACC:   rd = cfg_q.profAcc;
					REG_PROF_DEC:   rd = cfg_q.profDec;
					REG_HOME_ACC:   rd = cfg_q.homeAcc;
					REG_HOME_SPD:   rd = cfg_q.homeSpd;
					REG_SYNC_OFS:   rd = cfg_q.syncOfs;
					REG_SLAVE_POS:  rd = eng_q.pos;
					REG_SLAVE_SPD:  rd = eng_q.spd;
					REG_MASTER_POS: rd = eng_q.mPos;
					default:        rdOk = 1'b0;
				endcase
			end
			rsp_d.rvalid = 1'b1;
			rsp_d.rdata = rdOk ? rd : '0;
			rsp_d.rresp = rdOk ? RESP_OKAY : RESP_SLVERR;
		end
		rsp_d.awready = !bus_d.awHave && !rsp_d.bvalid;
		rsp_d.wready = !bus_d.wHave && !rsp_d.bvalid;
		rsp_d.arready = !rsp_d.rvalid;
	end

	always_comb begin
		logic               tick;
		logic               gearRise;
		logic               corrRise;
		logic               phaseRise;
		logic               direct;
		logic signed [31:0] tgtSpd;
		logic signed [31:0] err;
		logic [31:0]        step;
		logic [31:0]        mag;
		eng_d = eng_q;
		direct = cfg_q.ctrl[CW_DIRECT];
		gearRise = cfg_q.ctrl[CW_START_GEAR] && !eng_q.ctrlPrev[0];
		corrRise = cfg_q.ctrl[CW_START_CORR] && !eng_q.ctrlPrev[1];
		phaseRise = cfg_q.ctrl[CW_START_PHASE] && !eng_q.ctrlPrev[2];
		eng_d.ctrlPrev = {cfg_q.ctrl[CW_START_PHASE], cfg_q.ctrl[CW_START_CORR], cfg_q.ctrl[CW_START_GEAR]};
		tick = (cfg_q.syncMode == SYNC_PDO1 && pdoStrobe[0]) || (cfg_q.syncMode == SYNC_PDO2 && pdoStrobe[1]) ||
			(cfg_q.syncMode == SYNC_PDO3 && pdoStrobe[2]) || (cfg_q.syncMode == SYNC_CYCLE && syncStrobe);
		tgtSpd = '0;
		err = '0;
		step = '0;
		mag = '0;
		if (corrTargetValid) begin
			eng_d.corrTgt = corrTargetIn;
		end
		if (masterIn.newData) begin
			eng_d.mPos = gear(masterIn.pos, cfg_q.gearNum, cfg_q.gearDen);
			eng_d.mSpd = gear(masterIn.spd, cfg_q.gearNum, cfg_q.gearDen);
			eng_d.fresh = 1'b1;
		end else if (tick) begin
			// Only PDO1 and SYNC ticks extrapolate; the other two modes hold the last sample.
			if (!eng_q.fresh && (cfg_q.syncMode == SYNC_PDO1 || cfg_q.syncMode == SYNC_CYCLE)) begin
				eng_d.mPos = eng_q.mPos + eng_q.mSpd;
			end
			eng_d.fresh = 1'b0;
		end
		if (!cfg_q.ctrl[CW_START_GEAR]) begin
			eng_d.syncErr = 1'b0;
			if (eng_q.state != ST_IDLE) begin
				eng_d.state = ST_IDLE;
				eng_d.tgtReached = 1'b0;
			end
		end else if (gearRise) begin
			if (cfg_q.syncMode == SYNC_OFF) begin
				eng_d.syncErr = 1'b1;
			end else begin
				eng_d.state = ST_ACCEL;
				eng_d.tgtReached = 1'b0;
				eng_d.accCur = '0;
				eng_d.inGearCnt = '0;
				eng_d.engOfs = eng_q.pos - eng_q.mPos;
			end
		end else if (cfg_q.ctrl[CW_HALT] && eng_q.state != ST_IDLE && eng_q.state != ST_HALT) begin
			eng_d.state = ST_HALT;
			eng_d.tgtReached = 1'b0;
		end else if (!cfg_q.ctrl[CW_HALT] && eng_q.state == ST_HALT) begin
			eng_d.state = ST_ACCEL;
			eng_d.tgtReached = 1'b0;
			eng_d.accCur = '0;
			eng_d.inGearCnt = '0;
		end else if (corrRise && eng_q.state == ST_COUPLED && eng_q.tgtReached) begin
			eng_d.state = ST_CORR;
			eng_d.corrOk = 1'b0;
			eng_d.phDone = 1'b0;
		end else if (eng_q.state == ST_CORR && !cfg_q.ctrl[CW_START_CORR]) begin
			eng_d.state = ST_COUPLED;
			eng_d.phDone = 1'b1;
			eng_d.engOfs = eng_q.pos - eng_q.mPos;
		end else if (cfg_q.gearResync && eng_q.state == ST_COUPLED &&
				(cfg_q.gearNum != eng_q.lastNum || cfg_q.gearDen != eng_q.lastDen)) begin
			eng_d.state = ST_ACCEL;
			eng_d.tgtReached = 1'b0;
			eng_d.inGearCnt = '0;
		end
		eng_d.lastNum = cfg_q.gearNum;
		eng_d.lastDen = cfg_q.gearDen;
		if (phaseRise && (eng_q.state == ST_ACCEL || eng_q.state == ST_COUPLED)) begin
			eng_d.phSel = cfg_q.ctrl[CW_PROF_LSB +: 2];
			eng_d.phRem = absv($signed(cfg_q.phOfs[cfg_q.ctrl[CW_PROF_LSB +: 2]]));
			eng_d.phNeg = cfg_q.phOfs[cfg_q.ctrl[CW_PROF_LSB +: 2]][31];
			eng_d.phSpdCur = '0;
			eng_d.phDone = 1'b0;
		end
		if (tick) begin
			if (eng_q.phRem != '0 && eng_q.state != ST_CORR) begin
				mag = absv(ramp(eng_q.phSpdCur, $signed(cfg_q.phSpd[eng_q.phSel]), cfg_q.phAcc[eng_q.phSel]));
				if (eng_q.phRem <= mag) begin
					mag = eng_q.phRem;
					eng_d.phDone = 1'b1;
				end
				eng_d.phRem = eng_q.phRem - mag;
				eng_d.phSpdCur = eng_q.phNeg ? -$signed(mag) : $signed(mag);
			end else begin
				eng_d.phSpdCur = '0;
			end
			tgtSpd = eng_q.mSpd + eng_d.phSpdCur;
			unique case (eng_q.state)
				ST_IDLE: begin
					eng_d.spd = ramp(eng_q.spd, '0, cfg_q.profDec);
				end
				ST_ACCEL: begin
					if (direct) begin
						step = cfg_q.profAcc >> SCURVE_SHIFT;
						step = (step == '0) ? SCURVE_MIN_STEP : step;
						eng_d.accCur = (eng_q.accCur + step >= cfg_q.profAcc) ? cfg_q.profAcc : eng_q.accCur + step;
						eng_d.spd = ramp(eng_q.spd, tgtSpd, eng_d.accCur);
					end else begin
						eng_d.spd = ramp(eng_q.spd, tgtSpd, cfg_q.profAcc);
					end
					if (eng_d.spd == tgtSpd) begin
						eng_d.state = ST_COUPLED;
						eng_d.inGearCnt = '0;
						if (!direct) begin
							eng_d.engOfs = eng_q.pos - eng_q.mPos;
							eng_d.startPos = eng_q.pos;
						end
					end
				end
				ST_COUPLED: begin
					eng_d.spd = tgtSpd;
					if (direct) begin
						err = eng_q.mPos + eng_q.engOfs - eng_q.pos;
						eng_d.spd = tgtSpd + (err >>> POS_GAIN_SHIFT);
					end
					if (absv(eng_d.spd - tgtSpd) <= cfg_q.inGearThr) begin
						if (eng_q.inGearCnt >= cfg_q.inGearTime) begin
							eng_d.tgtReached = 1'b1;
						end else begin
							eng_d.inGearCnt = eng_q.inGearCnt + 32'h0000_0001;
						end
					end else begin
						eng_d.inGearCnt = '0;
					end
				end
				ST_HALT: begin
					eng_d.spd = ramp(eng_q.spd, '0, cfg_q.profDec);
					if (eng_d.spd == '0) begin
						eng_d.tgtReached = 1'b1;
					end
				end
				ST_CORR: begin
					// Distance is assumed within the 32-bit user range; no wrap guard is built.
					err = eng_q.corrTgt + cfg_q.syncOfs - eng_q.pos;
					mag = absv(eng_q.spd) + cfg_q.homeAcc;
					mag = (mag > cfg_q.homeSpd) ? cfg_q.homeSpd : mag;
					if (absv(err) <= mag) begin
						eng_d.spd = '0;
						eng_d.pos = eng_q.pos + err;
						eng_d.corrOk = 1'b1;
						eng_d.phDone = 1'b1;
						eng_d.state = ST_COUPLED;
						eng_d.engOfs = eng_q.pos + err - eng_q.mPos;
					end else begin
						eng_d.spd = err[31] ? -$signed(mag) : $signed(mag);
					end
				end
			endcase
			if (!(eng_q.state == ST_CORR && eng_d.state == ST_COUPLED)) begin
				eng_d.pos = eng_q.pos + eng_d.spd;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= '0;
			bus_q <= '0;
			rsp_q <= '0;
			eng_q <= '0;
		end else begin
			cfg_q <= cfg_d;
			bus_q <= bus_d;
			rsp_q <= rsp_d;
			eng_q <= eng_d;
		end
	end

	assign axiRsp = rsp_q;
	assign driveOut = '{spd: eng_q.spd, pos: eng_q.pos};
	assign syncMissingError = eng_q.syncErr;

endmodule : electronic_gear_slave_control

// >>> dv/egear_master_model.sv
`timescale 1ns/1ns
// Master drive: one telegram burst per period, then fresh values only with the pulse.
module egear_master_model
	import egear_pkg::*;
#(
	parameter int PERIOD = 20
)(
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	input  wire logic signed [31:0] mSpd,
	input  wire logic signed [31:0] mPos,
	input  wire logic               sendTgt,
	input  wire logic signed [31:0] tgt,
	output master_in_t              masterIn,
	output logic [2:0]              pdoStrobe,
	output logic                    syncStrobe,
	output logic                    corrTargetValid,
	output logic signed [31:0]      corrTargetIn
);
	int  cnt;
	wire last = (cnt == PERIOD - 1);
	// Stale words are inverted so that nothing may rely on a value outside its pulse.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cnt             <= 0;
			masterIn        <= '0;
			pdoStrobe       <= 3'h0;
			syncStrobe      <= 1'b0;
			corrTargetValid <= 1'b0;
			corrTargetIn    <= '0;
		end else begin
			cnt              <= last ? 0 : cnt + 1;
			syncStrobe       <= last;
			pdoStrobe        <= {1'b0, sendTgt, last};
			masterIn.newData <= last;
			masterIn.pos     <= last ? mPos : ~masterIn.pos;
			masterIn.spd     <= last ? mSpd : ~masterIn.spd;
			corrTargetValid  <= sendTgt;
			corrTargetIn     <= sendTgt ? tgt : ~corrTargetIn;
		end
	end
endmodule : egear_master_model

// >>> dv/electronic_gear_slave_control_chk.sv
`timescale 1ns/1ns
module electronic_gear_slave_control_chk
	import egear_pkg::*;
(
	input wire logic               ref_clk,
	input wire logic               rstn,
	input wire axil_req_t          axiReq,
	input wire axil_rsp_t          axiRsp,
	input wire master_in_t         masterIn,
	input wire logic [2:0]         pdoStrobe,
	input wire logic               syncStrobe,
	input wire logic               corrTargetValid,
	input wire logic signed [31:0] corrTargetIn,
	input wire drive_out_t         driveOut,
	input wire logic               syncMissingError
);
	logic [3:0] sinceWr_q;
	logic [3:0] sinceWr_d;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Saturates so a long quiet spell never wraps back into the window.
	always_comb begin
		sinceWr_d = (sinceWr_q == 4'hF) ? sinceWr_q : sinceWr_q + 4'h1;
		if (axiRsp.bvalid) begin
			sinceWr_d = 4'h0;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sinceWr_q <= 4'hF;
		end else begin
			sinceWr_q <= sinceWr_d;
		end
	end
	sequence wrTaken;
		axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
	endsequence
	sequence rdTaken;
		axiReq.arvalid && axiRsp.arready;
	endsequence
	sequence noTick;
		pdoStrobe == 3'h0 && !syncStrobe;
	endsequence
	AST_WR_LAT: assert property (wrTaken |=> !axiRsp.bvalid ##1 axiRsp.bvalid)
		else $error("write answer timing");
	AST_RD_LAT: assert property (rdTaken |=> axiRsp.rvalid)
		else $error("read answer timing");
	AST_B_DONE: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid && axiRsp.awready && axiRsp.wready)
		else $error("write channel not reopened");
	AST_R_DONE: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid && axiRsp.arready)
		else $error("read channel not reopened");
	AST_W_REFUSE: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
		else $error("write accepted while answer pending");
	AST_AR_REFUSE: assert property (axiRsp.rvalid |-> !axiRsp.arready)
		else $error("read accepted while answer pending");
	AST_IDLE_HOLD: assert property (noTick |=> $stable(driveOut))
		else $error("drive command moved without a tick");
	AST_ERR_CAUSE: assert property ($changed(syncMissingError) |-> sinceWr_q < 4'h5)
		else $error("sync error flag changed without a control write");
endmodule : electronic_gear_slave_control_chk
bind electronic_gear_slave_control electronic_gear_slave_control_chk electronic_gear_slave_control_chk_inst (
	.ref_clk(ref_clk), .rstn(rstn), .axiReq(axiReq), .axiRsp(axiRsp), .masterIn(masterIn),
	.pdoStrobe(pdoStrobe), .syncStrobe(syncStrobe), .corrTargetValid(corrTargetValid),
	.corrTargetIn(corrTargetIn), .driveOut(driveOut), .syncMissingError(syncMissingError));

// >>> dv/electronic_gear_slave_control_bench.sv
`timescale 1ns/1ns
module electronic_gear_slave_control_bench
	import egear_pkg::*;
;
	logic               ref_clk = 1'b0;
	logic               rstn = 1'b0;
	axil_req_t          axiReq = '0;
	axil_rsp_t          axiRsp;
	master_in_t         masterIn;
	logic [2:0]         pdoStrobe;
	logic               syncStrobe;
	logic               corrTargetValid;
	logic signed [31:0] corrTargetIn;
	drive_out_t         driveOut;
	logic               syncMissingError;
	logic signed [31:0] mSpd = 32'h0000_0032;
	logic signed [31:0] mPos = 32'h0000_03E8;
	logic               sendTgt = 1'b0;
	logic signed [31:0] tgt = '0;
	int                 numErrors = 0;
	int                 cmpCount = 0;
	logic [31:0]        rdat;
	logic [1:0]         resp;
	logic [31:0]        p;
	always #4 ref_clk = ~ref_clk;
	electronic_gear_slave_control electronic_gear_slave_control_inst (
		.ref_clk(ref_clk), .rstn(rstn), .axiReq(axiReq), .axiRsp(axiRsp), .masterIn(masterIn),
		.pdoStrobe(pdoStrobe), .syncStrobe(syncStrobe), .corrTargetValid(corrTargetValid),
		.corrTargetIn(corrTargetIn), .driveOut(driveOut), .syncMissingError(syncMissingError));
	egear_master_model egear_master_model_inst (
		.ref_clk(ref_clk), .rstn(rstn), .mSpd(mSpd), .mPos(mPos), .sendTgt(sendTgt), .tgt(tgt),
		.masterIn(masterIn), .pdoStrobe(pdoStrobe), .syncStrobe(syncStrobe),
		.corrTargetValid(corrTargetValid), .corrTargetIn(corrTargetIn));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Handshake flags are sampled mid-cycle, so the decision never races the edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		logic b;
		@(posedge ref_clk);
		axiReq.awvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wvalid <= 1'b1;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hF;
		axiReq.bready <= 1'b1;
		do begin
			@(negedge ref_clk);
			aw = axiRsp.awready;
			w = axiRsp.wready;
			b = axiRsp.bvalid;
			resp = axiRsp.bresp;
			@(posedge ref_clk);
			if (aw) axiReq.awvalid <= 1'b0;
			if (w) axiReq.wvalid <= 1'b0;
		end while (!b);
		axiReq.bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		logic ar;
		logic v;
		@(posedge ref_clk);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		axiReq.rready <= 1'b1;
		do begin
			@(negedge ref_clk);
			ar = axiRsp.arready;
			v = axiRsp.rvalid;
			rdat = axiRsp.rdata;
			resp = axiRsp.rresp;
			@(posedge ref_clk);
			if (ar) axiReq.arvalid <= 1'b0;
		end while (!v);
		axiReq.rready <= 1'b0;
	endtask : rd
	task automatic waitBit(input int b, input logic v);
		int n;
		n = 0;
		do begin
			rd(REG_STATUS);
			n++;
		end while (rdat[b] !== v && n < 300);
		chk("status bit", {31'h0, v}, {31'h0, rdat[b]});
	endtask : waitBit
	task automatic send(input logic [31:0] v);
		@(posedge ref_clk);
		tgt <= v;
		sendTgt <= 1'b1;
		@(posedge ref_clk);
		sendTgt <= 1'b0;
	endtask : send
	task automatic tReset();
		rd(REG_STATUS);
		chk("status after reset", '0, rdat);
		rd(8'h4C);
		chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
		chk("unmapped read data", '0, rdat);
	endtask : tReset
	task automatic tSyncErr();
		wr(REG_CTRL, 32'h0000_0010);
		waitBit(SW_SYNC_ERR, 1'b1);
		@(negedge ref_clk);
		chk("sync error pin", 32'h1, {31'h0, syncMissingError});
		chk("speed without sync", '0, driveOut.spd);
		wr(REG_CTRL, '0);
		waitBit(SW_SYNC_ERR, 1'b0);
	endtask : tSyncErr
	task automatic tCorrRefused();
		wr(REG_SYNC_MODE, {28'h0, SYNC_CYCLE});
		wr(REG_CTRL, 32'h0000_0020);
		repeat (60) @(posedge ref_clk);
		rd(REG_STATUS);
		chk("refused correction", '0, rdat & 32'h0000_1500);
		wr(REG_CTRL, '0);
	endtask : tCorrRefused
	task automatic tGear();
		wr(REG_GEAR_NUM, 32'h0000_0002);
		wr(REG_GEAR_DEN, 32'h0000_0001);
		wr(REG_INGEAR_THR, 32'h0000_0002);
		wr(REG_INGEAR_TIM, 32'h0000_0002);
		wr(REG_PROF_ACC, 32'h0000_0005);
		wr(REG_PROF_DEC, 32'h0000_0014);
		wr(REG_CTRL, 32'h0000_0010);
		rd(REG_STATUS);
		chk("coupled during ramp", '0, {31'h0, rdat[SW_TARGET]});
		waitBit(SW_TARGET, 1'b1);
		@(negedge ref_clk);
		chk("coupled speed", 32'h0000_0064, driveOut.spd);
		@(posedge ref_clk);
		mSpd <= 32'h0000_004B;
		repeat (50) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("coupled follows master", 32'h0000_0096, driveOut.spd);
	endtask : tGear
	task automatic tHalt();
		wr(REG_CTRL, 32'h0000_0110);
		waitBit(SW_TARGET, 1'b0);
		waitBit(SW_TARGET, 1'b1);
		@(negedge ref_clk);
		chk("halted speed", '0, driveOut.spd);
		@(posedge ref_clk);
		mSpd <= '0;
		wr(REG_CTRL, 32'h0000_0010);
		waitBit(SW_TARGET, 1'b1);
		rd(REG_MASTER_POS);
		chk("scaled master position", 32'h0000_07D0, rdat);
	endtask : tHalt
	task automatic tCorr();
		wr(REG_SYNC_OFS, 32'h0000_0008);
		wr(REG_HOME_ACC, 32'h0000_000A);
		wr(REG_HOME_SPD, 32'h0000_0028);
		rd(REG_SLAVE_POS);
		p = rdat;
		send(p + 32'h0000_012C);
		wr(REG_CTRL, 32'h0000_0030);
		rd(REG_STATUS);
		chk("correction running", '0, rdat & 32'h0000_1100);
		waitBit(SW_PHASE_DONE, 1'b1);
		rd(REG_STATUS);
		chk("correction ok", 32'h0000_1000, rdat & 32'h0000_1000);
		rd(REG_SLAVE_POS);
		chk("corrected position", p + 32'h0000_0134, rdat);
		wr(REG_CTRL, 32'h0000_0010);
		send(p + 32'h0001_86A0);
		wr(REG_CTRL, 32'h0000_0030);
		rd(REG_STATUS);
		chk("second correction running", '0, rdat & 32'h0000_1100);
		wr(REG_CTRL, 32'h0000_0010);
		waitBit(SW_PHASE_DONE, 1'b1);
		rd(REG_STATUS);
		chk("cancelled correction", '0, rdat & 32'h0000_1000);
	endtask : tCorr
	task automatic tPhase();
		wr(8'h60, 32'h0000_003C);
		wr(8'h64, 32'h0000_0014);
		wr(8'h68, 32'h0000_000A);
		rd(REG_SLAVE_POS);
		p = rdat;
		wr(REG_CTRL, 32'h0000_2210);
		rd(REG_STATUS);
		chk("phasing running", '0, {31'h0, rdat[SW_PHASE_DONE]});
		waitBit(SW_PHASE_DONE, 1'b1);
		rd(REG_SLAVE_POS);
		chk("phased position", p + 32'h0000_003C, rdat);
		@(negedge ref_clk);
		chk("phased drive position", p + 32'h0000_003C, driveOut.pos);
	endtask : tPhase
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		tReset();
		tSyncErr();
		tCorrRefused();
		tGear();
		tHalt();
		tCorr();
		tPhase();
		conclude();
	end
	// Generous against the slowest polls; a hang still ends with a verdict.
	initial begin
		repeat (60000) @(posedge ref_clk);
		numErrors++;
		conclude();
	end
endmodule : electronic_gear_slave_control_bench
